// File: core/stsq_pkg.sv
package stsq_pkg;
  // unlock keys, written in this order to the key word
  localparam logic [31:0] KEY_FIRST        = 32'h753f924e;
  localparam logic [31:0] KEY_SECOND       = 32'h8ac06db1;
  localparam logic [4:0]  KEY_ACCESS_LIMIT = 5'h1e;
  localparam logic [4:0]  ACCESS_CNT_RESET = 5'h00;

  // partition map: pointers below LOGIC_BASE are memory partitions
  localparam int          NMEM       = 96;
  localparam int          NLOG       = 4;
  localparam logic [6:0]  PTR_END    = 7'h7f;
  localparam logic [6:0]  LOGIC_BASE = 7'h60;
  localparam logic [6:0]  FIRST_PTR_RESET = 7'h7f;

  // logic test runs at a quarter of the test clock
  localparam int          PLL_MHZ   = 200;
  localparam int          LOGIC_MHZ = 50;
  localparam logic [7:0]  LOGIC_DIV = 8'(PLL_MHZ / LOGIC_MHZ);
  localparam logic [7:0]  SHIFT_LEN = 8'h10;
  localparam logic [7:0]  FLUSH_LEN = 8'h08;

  // control word fields
  localparam int PTR_LSB      = 0;
  localparam int CSM_BIT      = 7;
  localparam int SHS_LSB      = 8;
  localparam int SCAN_ENABLE_OFF_DELAY_LSB = 11;
  localparam int SCAN_ENABLE_ON_DELAY_LSB  = 15;
  localparam int PFT_BIT      = 19;
  localparam int CWS_LSB      = 20;
  localparam int PATTERN_GENERATOR_LOAD_ENABLE_BIT   = 23;
  localparam logic [7:0]  MEM_CTRL_RESET   = 8'h7f;
  localparam logic [31:0] LOGIC_CTRL_RESET = 32'h0072a87f;
  localparam logic [15:0] PCS_RESET        = 16'h0000;

  // run control fields
  localparam int RUN_BIT       = 0;
  localparam int MEM_PLL_BIT   = 1;
  localparam int LOGIC_PLL_BIT = 2;
  localparam int IRQ_EN_BIT    = 3;
  localparam logic [3:0]  RUN_CFG_RESET = 4'h0;

  localparam logic [31:0] WDG_RESET = 32'h0000ffff;

  typedef enum logic [2:0] {
    SEL_KEY, SEL_MEM_CTRL, SEL_LOGIC_CTRL, SEL_PATTERN_COUNT,
    SEL_FAULT_MAP, SEL_RUN, SEL_WATCHDOG, SEL_FIRST_PTR
  } stsq_sel_t;
endpackage

// File: core/stsq_sequencer.sv
// Behaviour
// - separate offline memory and online logic result copies
// - offline memory results held in six words
// - logic chain end pulses functional reset
// - unlock only after two keys in order
// - relock unless second key within 30 accesses
// - memory mode bit selects concurrent next partition
// - memory next pointer, 0x7f ends chain
// - per partition fault recoverable or unrecoverable
// - logic next pointer, 0x7f ends chain
// - shift speed field sets scan shift rate
// - scan enable off and on delays
// - flush patterns first when flush bit zero
// - apply programmed pattern count per partition
// - run bit starts test, selects clocks, irq
// - watchdog resets device on stalled progress
// - logic test divided to quarter rate
module stsq_sequencer
  import stsq_pkg::*;
(
  // clock and reset
  input  logic                  ref_clk_in,
  input  logic                  sys_rst_in,
  // configuration writes and offline start
  input  logic                  cfg_wr_in,
  input  stsq_pkg::stsq_sel_t   cfg_sel_in,
  input  logic [6:0]            cfg_idx_in,
  input  logic [31:0]           cfg_data_in,
  input  logic                  offline_start_in,
  // memory test engines
  input  logic                  mem_done_in,
  input  logic [6:0]            mem_done_part_in,
  input  logic                  mem_fail_in,
  output logic                  mem_start_out,
  output logic [6:0]            mem_part_out,
  // logic test engine
  input  logic                  logic_fail_in,
  output logic [1:0]            logic_part_out,
  output logic                  scan_enable_out,
  output logic                  shift_clk_en_out,
  output logic                  capture_out,
  output logic                  flush_out,
  output logic [2:0]            compactor_width_select_out,
  // clock selection and status
  output logic                  mem_pll_sel_out,
  output logic                  logic_pll_sel_out,
  output logic                  unlocked_out,
  output logic                  busy_out,
  // system events
  output logic                  func_reset_out,
  output logic                  wdg_reset_out,
  output logic                  end_irq_out,
  output logic                  fault_recoverable_out,
  output logic                  fault_unrecoverable_out,
  // results
  output logic [31:0]           memtest_status_low_out,
  output logic [31:0]           memtest_status_mid_out,
  output logic [31:0]           memtest_status_high_out,
  output logic [31:0]           memtest_error_low_out,
  output logic [31:0]           memtest_error_mid_out,
  output logic [31:0]           memtest_error_high_out,
  output logic [31:0]           online_logictest_status_out,
  output logic [31:0]           online_logictest_error_out
);
  import stsq_pkg::*;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} stsq_key_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_MEM_LAUNCH, ST_MEM_WAIT, ST_LB_START, ST_LB_FLUSH, ST_LB_SHIFT,
    ST_LB_SE_OFF, ST_LB_CAPTURE, ST_LB_SE_ON, ST_LB_NEXT, ST_FINISH
  } stsq_state_t;

  stsq_key_t   key_state;
  logic [4:0]  access_cnt;
  logic [7:0]  mem_ctrl [NMEM];
  logic [31:0] logic_ctrl [NLOG];
  logic [15:0] pattern_count [NLOG];
  logic [NMEM-1:0] fault_map, mem_status, mem_error;
  logic [3:0]  run_cfg;
  logic [31:0] wdg_timeout, wdg_cnt;
  logic [6:0]  first_ptr, cur_ptr, hop_ptr, next_cur;
  logic [7:0]  outstanding, bit_cnt;
  logic [3:0]  dly_cnt;
  logic [15:0] pat_left;
  logic        offline_run, logic_ran;
  stsq_state_t state, next_state;

  // write decode
  wire key_wr   = cfg_wr_in && (cfg_sel_in == SEL_KEY);
  wire is_key2  = key_wr && (cfg_data_in == KEY_SECOND);
  wire unlocked = key_state == KEY_OPEN;
  wire cfg_ok   = cfg_wr_in && unlocked && (cfg_sel_in != SEL_KEY);
  wire wr_mem   = cfg_ok && cfg_sel_in == SEL_MEM_CTRL && cfg_idx_in < LOGIC_BASE;
  wire wr_log   = cfg_ok && cfg_sel_in == SEL_LOGIC_CTRL && cfg_idx_in < 7'(NLOG);
  wire wr_pcs   = cfg_ok && cfg_sel_in == SEL_PATTERN_COUNT && cfg_idx_in < 7'(NLOG);
  wire wr_run   = cfg_ok && cfg_sel_in == SEL_RUN;
  wire start_on = wr_run && cfg_data_in[RUN_BIT] && state == ST_IDLE;
  wire start_off = offline_start_in && state == ST_IDLE && !start_on;
  wire start    = start_on || start_off;

  // current partition words
  wire        cur_is_mem = cur_ptr < LOGIC_BASE;
  wire [1:0]  lidx       = 2'(cur_ptr - LOGIC_BASE);
  wire [7:0]  cur_mem    = cur_is_mem ? mem_ctrl[cur_ptr] : MEM_CTRL_RESET;
  wire [31:0] cur_log    = logic_ctrl[lidx];
  wire [6:0]  mem_next   = cur_mem[PTR_LSB +: 7];
  wire        mem_conc   = cur_mem[CSM_BIT];
  wire [6:0]  log_next   = cur_log[PTR_LSB +: 7];
  wire [2:0]  scan_shift_speed        = cur_log[SHS_LSB +: 3];
  wire [3:0]  scan_enable_off_delay   = cur_log[SCAN_ENABLE_OFF_DELAY_LSB +: 4];
  wire [3:0]  scan_enable_on_delay    = cur_log[SCAN_ENABLE_ON_DELAY_LSB +: 4];
  wire        flush_pattern_control        = cur_log[PFT_BIT];

  // rate ticks: quarter rate for logic test, then shift speed on top
  wire logic_tick, shift_tick;
  wire div_clear = state == ST_IDLE;
  stsq_tick_div u_logic_div (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .clear_in   (div_clear),
    .en_in      (1'b1),
    .div_in     (LOGIC_DIV),
    .tick_out   (logic_tick)
  );
  stsq_tick_div u_shift_div (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .clear_in   (div_clear),
    .en_in      (logic_tick),
    .div_in     ({5'h00, scan_shift_speed} + 8'h01),
    .tick_out   (shift_tick)
  );

  wire launch    = state == ST_MEM_LAUNCH;
  wire shifting  = state == ST_LB_FLUSH || state == ST_LB_SHIFT;
  wire bit_last  = bit_cnt == ((state == ST_LB_FLUSH ? FLUSH_LEN : SHIFT_LEN) - 8'h01);
  wire lb_done   = state == ST_LB_NEXT;
  wire cap_now   = state == ST_LB_CAPTURE && logic_tick;
  wire progress  = start || launch || mem_done_in || cap_now || lb_done;
  wire wdg_fire  = state != ST_IDLE && wdg_cnt == 32'h0;
  wire [7:0] out_next = outstanding + {7'h00, launch} - {7'h00, mem_done_in && outstanding != 8'h00};

  always_comb begin
    next_state = state;
    next_cur   = cur_ptr;
    unique case (state)
      ST_IDLE: if (start) begin
        next_cur   = first_ptr;
        next_state = first_ptr == PTR_END ? ST_FINISH :
                     first_ptr < LOGIC_BASE ? ST_MEM_LAUNCH : ST_LB_START;
      end
      ST_MEM_LAUNCH: if (mem_conc && mem_next < LOGIC_BASE) next_cur = mem_next;
                     else next_state = ST_MEM_WAIT;
      ST_MEM_WAIT: if (outstanding == 8'h00) begin
        next_cur   = hop_ptr;
        next_state = hop_ptr == PTR_END ? ST_FINISH :
                     hop_ptr < LOGIC_BASE ? ST_MEM_LAUNCH : ST_LB_START;
      end
      ST_LB_START: next_state = pattern_count[lidx] == 16'h0 ? ST_LB_NEXT :
                                !flush_pattern_control ? ST_LB_FLUSH : ST_LB_SHIFT;
      ST_LB_FLUSH: if (shift_tick && bit_last) next_state = ST_LB_SHIFT;
      ST_LB_SHIFT: if (shift_tick && bit_last) next_state = ST_LB_SE_OFF;
      ST_LB_SE_OFF: if (logic_tick && dly_cnt == scan_enable_off_delay) next_state = ST_LB_CAPTURE;
      ST_LB_CAPTURE: if (logic_tick) next_state = ST_LB_SE_ON;
      ST_LB_SE_ON: if (logic_tick && dly_cnt == scan_enable_on_delay)
                     next_state = pat_left == 16'h1 ? ST_LB_NEXT : ST_LB_SHIFT;
      ST_LB_NEXT: begin
        // a logic pointer that names a memory partition ends the chain safely
        next_cur   = log_next;
        next_state = (log_next == PTR_END || log_next < LOGIC_BASE) ? ST_FINISH : ST_LB_START;
      end
      ST_FINISH: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (wdg_fire) next_state = ST_IDLE;
  end

  // key lock: second key must recur before the access budget runs out
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_state  <= KEY_LOCKED;
      access_cnt <= ACCESS_CNT_RESET;
    end else if (cfg_wr_in) begin
      unique case (key_state)
        KEY_LOCKED: if (key_wr && cfg_data_in == KEY_FIRST) key_state <= KEY_HALF;
        KEY_HALF: key_state <= is_key2 ? KEY_OPEN : KEY_LOCKED;
        KEY_OPEN: if (is_key2) access_cnt <= ACCESS_CNT_RESET;
                  else if (access_cnt + 5'h01 >= KEY_ACCESS_LIMIT) key_state <= KEY_LOCKED;
                  else access_cnt <= access_cnt + 5'h01;
      endcase
      if (key_state != KEY_OPEN) access_cnt <= ACCESS_CNT_RESET;
    end
  end

  // configuration store, each item live as soon as written
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NMEM; i++) mem_ctrl[i] <= MEM_CTRL_RESET;
      for (int i = 0; i < NLOG; i++) logic_ctrl[i] <= LOGIC_CTRL_RESET;
      for (int i = 0; i < NLOG; i++) pattern_count[i] <= PCS_RESET;
      fault_map   <= '0;
      run_cfg     <= RUN_CFG_RESET;
      wdg_timeout <= WDG_RESET;
      first_ptr   <= FIRST_PTR_RESET;
    end else begin
      if (wr_mem) mem_ctrl[cfg_idx_in] <= cfg_data_in[7:0];
      if (wr_log) logic_ctrl[cfg_idx_in[1:0]] <= cfg_data_in;
      if (wr_pcs) pattern_count[cfg_idx_in[1:0]] <= cfg_data_in[15:0];
      if (cfg_ok && cfg_sel_in == SEL_FAULT_MAP && cfg_idx_in < 7'h03)
        fault_map[32*cfg_idx_in[1:0] +: 32] <= cfg_data_in;
      if (wr_run) run_cfg <= cfg_data_in[3:0];
      if (cfg_ok && cfg_sel_in == SEL_WATCHDOG) wdg_timeout <= cfg_data_in;
      if (cfg_ok && cfg_sel_in == SEL_FIRST_PTR) first_ptr <= cfg_data_in[6:0];
    end
  end

  // sequencer state and counters
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      cur_ptr <= PTR_END;
      hop_ptr <= PTR_END;
      outstanding <= 8'h00;
      offline_run <= 1'b0;
      logic_ran <= 1'b0;
      wdg_cnt <= WDG_RESET;
    end else begin
      state <= next_state;
      cur_ptr <= next_cur;
      outstanding <= wdg_fire ? 8'h00 : out_next;
      if (launch) hop_ptr <= mem_next;
      if (start) offline_run <= start_off;
      if (start) logic_ran <= 1'b0;
      else if (lb_done) logic_ran <= 1'b1;
      if (progress) wdg_cnt <= wdg_timeout;
      else if (state != ST_IDLE && wdg_cnt != 32'h0) wdg_cnt <= wdg_cnt - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt <= 8'h00;
      dly_cnt <= 4'h0;
      pat_left <= PCS_RESET;
    end else begin
      if (state == ST_LB_START) pat_left <= pattern_count[lidx];
      else if (state == ST_LB_SE_ON && next_state != ST_LB_SE_ON) pat_left <= pat_left - 16'h1;
      if (!shifting || (shift_tick && bit_last)) bit_cnt <= 8'h00;
      else if (shift_tick) bit_cnt <= bit_cnt + 8'h01;
      if (state != next_state) dly_cnt <= 4'h0;
      else if (logic_tick) dly_cnt <= dly_cnt + 4'h1;
    end
  end

  // results: offline memory words and online logic words are kept apart
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_status <= '0;
      mem_error <= '0;
      online_logictest_status_out <= 32'h0;
      online_logictest_error_out <= 32'h0;
    end else begin
      if (start_off) begin
        mem_status <= '0;
        mem_error <= '0;
      end
      // a completion in the clearing cycle lands only if offline_run is already set from the last run: the set wins
      if (mem_done_in && offline_run && mem_done_part_in < LOGIC_BASE) begin
        mem_status[mem_done_part_in] <= 1'b1;
        if (mem_fail_in) mem_error[mem_done_part_in] <= 1'b1;
      end
      if (start_on) begin
        online_logictest_status_out <= 32'h0;
        online_logictest_error_out <= 32'h0;
      end else if (lb_done && !offline_run) begin
        online_logictest_status_out[lidx] <= 1'b1;
        online_logictest_error_out[lidx] <= logic_fail_in;
      end
    end
  end

  // registered outputs
  wire part_unrec = mem_done_part_in < LOGIC_BASE && fault_map[mem_done_part_in];
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_start_out <= 1'b0;
      mem_part_out <= PTR_END;
      logic_part_out <= 2'h0;
      scan_enable_out <= 1'b0;
      shift_clk_en_out <= 1'b0;
      capture_out <= 1'b0;
      flush_out <= 1'b0;
      compactor_width_select_out <= 3'h0;
      func_reset_out <= 1'b0;
      wdg_reset_out <= 1'b0;
      end_irq_out <= 1'b0;
      fault_recoverable_out <= 1'b0;
      fault_unrecoverable_out <= 1'b0;
      busy_out <= 1'b0;
      unlocked_out <= 1'b0;
    end else begin
      mem_start_out <= launch;
      if (launch) mem_part_out <= cur_ptr;
      logic_part_out <= lidx;
      scan_enable_out <= shifting;
      shift_clk_en_out <= shifting && shift_tick;
      capture_out <= cap_now;
      flush_out <= state == ST_LB_FLUSH;
      compactor_width_select_out <= cur_log[CWS_LSB +: 3];
      func_reset_out <= state == ST_FINISH && logic_ran;
      wdg_reset_out <= wdg_fire;
      end_irq_out <= state == ST_FINISH && run_cfg[IRQ_EN_BIT];
      fault_recoverable_out <= mem_done_in && mem_fail_in && !part_unrec;
      fault_unrecoverable_out <= mem_done_in && mem_fail_in && part_unrec;
      busy_out <= next_state != ST_IDLE;
      unlocked_out <= unlocked;
    end
  end

  assign mem_pll_sel_out = run_cfg[MEM_PLL_BIT];
  assign logic_pll_sel_out = run_cfg[LOGIC_PLL_BIT];
  assign memtest_status_low_out = mem_status[31:0];
  assign memtest_status_mid_out = mem_status[63:32];
  assign memtest_status_high_out = mem_status[95:64];
  assign memtest_error_low_out = mem_error[31:0];
  assign memtest_error_mid_out = mem_error[63:32];
  assign memtest_error_high_out = mem_error[95:64];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_key_unlock_order: assert property ($rose(unlocked) |-> $past(key_state) == KEY_HALF && $past(is_key2))
    else $error("unlock without key pair");
  a_rekey_budget: assert property (unlocked && cfg_wr_in && !is_key2 && access_cnt == 5'h1d |=> !unlocked)
    else $error("stayed unlocked past access budget");
  a_locked_run_ignored: assert property (state == ST_IDLE && !unlocked && !offline_start_in |=> state == ST_IDLE)
    else $error("locked run started a test");
  a_mem_concurrent: assert property (launch && mem_conc && mem_next < LOGIC_BASE && !wdg_fire |=> launch ##1 mem_start_out)
    else $error("concurrent partition not launched");
  a_flush_first: assert property (state == ST_LB_START && !flush_pattern_control && pattern_count[lidx] != 16'h0 |=> ##1 flush_out)
    else $error("flush not applied first");
  a_capture_gap: assert property (capture_out |-> !scan_enable_out && $past(!scan_enable_out, 2))
    else $error("scan enable overlaps capture");
  a_logic_tick_rate: assert property (logic_tick |=> !logic_tick [*3])
    else $error("logic rate above quarter clock");
  a_logic_end_reset: assert property (lb_done && log_next == PTR_END && !wdg_fire |=> ##1 func_reset_out)
    else $error("no functional reset after chain");
  a_fault_class: assert property (mem_done_in && mem_fail_in |=> fault_unrecoverable_out == $past(part_unrec))
    else $error("fault class mismatch");
  a_wdg_fire: assert property (state != ST_IDLE && wdg_cnt == 32'h0 |=> state == ST_IDLE ##0 wdg_reset_out)
    else $error("watchdog did not abort");

  c_online_logic_done: cover property (func_reset_out && !offline_run);
  c_offline_mem_fail: cover property (mem_done_in && mem_fail_in && offline_run);
  c_rekey_kept: cover property (unlocked && is_key2 && access_cnt > 5'h10);
endmodule

// File: core/stsq_tick_div.sv
module stsq_tick_div (
  // clock and reset
  input  logic       ref_clk_in,
  input  logic       sys_rst_in,
  // control
  input  logic       clear_in,
  input  logic       en_in,
  input  logic [7:0] div_in,
  // tick
  output logic       tick_out
);
  logic [7:0] cnt;
  wire        wrap = (cnt + 8'h01) >= div_in;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end else if (clear_in) begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= en_in && wrap;
      if (en_in) cnt <= wrap ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule

// File: test/online_self_test_sequencer_tb.sv
module online_self_test_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stsq_pkg::*;
  logic        clk, rst, wr, off_start, done, fail;
  stsq_sel_t   sel;
  logic [6:0]  idx, done_part, mem_part;
  logic [31:0] data, st_low, er_low, st_mid, er_mid, st_high, er_high, ol_status, ol_error;
  logic        mem_start, capture, flush, unlocked, busy, func_reset, end_irq, f_rec, f_unrec, mpll, lpll;
  logic        scan_en, shift_en, wdg_rst, lfail;
  logic [1:0]  lpart, lpart_seen;
  logic [2:0]  compactor_width_select, cws_seen;
  logic [6:0]  parts[2];
  int          failures, checked, cyc, n_start, n_cap, n_fr, n_irq, n_rec, n_unrec, n_flush, flush_first;
  int          n_shift, n_wdg, n_se_cap;
  int          start_cyc[2];

  stsq_sequencer u_stsq_sequencer (
    .ref_clk_in(clk), .sys_rst_in(rst), .cfg_wr_in(wr), .cfg_sel_in(sel), .cfg_idx_in(idx),
    .cfg_data_in(data), .offline_start_in(off_start), .mem_done_in(done), .mem_done_part_in(done_part),
    .mem_fail_in(fail), .mem_start_out(mem_start), .mem_part_out(mem_part), .logic_fail_in(lfail),
    .logic_part_out(lpart), .scan_enable_out(scan_en), .shift_clk_en_out(shift_en), .capture_out(capture),
    .flush_out(flush), .compactor_width_select_out(compactor_width_select), .mem_pll_sel_out(mpll), .logic_pll_sel_out(lpll),
    .unlocked_out(unlocked), .busy_out(busy), .func_reset_out(func_reset), .wdg_reset_out(wdg_rst),
    .end_irq_out(end_irq), .fault_recoverable_out(f_rec), .fault_unrecoverable_out(f_unrec),
    .memtest_status_low_out(st_low), .memtest_status_mid_out(st_mid), .memtest_status_high_out(st_high),
    .memtest_error_low_out(er_low), .memtest_error_mid_out(er_mid), .memtest_error_high_out(er_high),
    .online_logictest_status_out(ol_status), .online_logictest_error_out(ol_error));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // event counters, cleared by each scenario before it starts the sequence
  always @(posedge clk) begin
    cyc++;
    if (mem_start === 1'b1) begin
      parts[n_start % 2] = mem_part;
      start_cyc[n_start % 2] = cyc;
      n_start++;
    end
    if (capture === 1'b1) begin
      n_cap++;
      cws_seen = compactor_width_select;
      lpart_seen = lpart;
      if (scan_en !== 1'b0) n_se_cap++;
      if (n_cap == 1) flush_first = n_flush;
    end
    if (shift_en === 1'b1) n_shift++;
    if (wdg_rst === 1'b1) n_wdg++;
    if (flush === 1'b1) n_flush++;
    if (func_reset === 1'b1) n_fr++;
    if (end_irq === 1'b1) n_irq++;
    if (f_rec === 1'b1) n_rec++;
    if (f_unrec === 1'b1) n_unrec++;
  end

  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout(input int i);
    if (i >= 3000) begin
      failures++;
      $display("ERROR %0t wait timed out", $time);
      end_of_test;
    end
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    timeout(i);
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_starts(input int n);
    int i;
    for (i = 0; i < 3000 && n_start < n; i++) @(negedge clk);
    timeout(i);
  endtask

  task automatic cfg(input stsq_sel_t s, input logic [6:0] ix, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1; sel = s; idx = ix; data = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic mem_done(input logic [6:0] p, input logic f);
    @(negedge clk);
    done = 1'b1; done_part = p; fail = f;
    @(negedge clk);
    done = 1'b0; fail = 1'b0;
  endtask

  task automatic unlock;
    cfg(SEL_KEY, 7'h00, KEY_FIRST);
    cfg(SEL_KEY, 7'h00, KEY_SECOND);
    repeat (2) @(negedge clk);
  endtask

  task automatic clear_counts;
    @(negedge clk);
    n_start = 0; n_cap = 0; n_fr = 0; n_irq = 0; n_rec = 0; n_unrec = 0; n_flush = 0;
    n_shift = 0;
    n_wdg = 0;
    n_se_cap = 0;
  endtask

  task automatic test_lock;
    chk(32'(unlocked), 32'h0);
    cfg(SEL_KEY, 7'h00, KEY_SECOND);
    cfg(SEL_KEY, 7'h00, KEY_FIRST);
    cfg(SEL_RUN, 7'h00, 32'h1);
    repeat (2) @(negedge clk);
    chk(32'(unlocked), 32'h0);
    chk(32'(busy), 32'h0);
    unlock;
    chk(32'(unlocked), 32'h1);
    repeat (20) cfg(SEL_WATCHDOG, 7'h00, WDG_RESET);
    cfg(SEL_KEY, 7'h00, KEY_SECOND);
    repeat (29) cfg(SEL_WATCHDOG, 7'h00, WDG_RESET);
    @(negedge clk);
    chk(32'(unlocked), 32'h1);
    cfg(SEL_WATCHDOG, 7'h00, WDG_RESET);
    repeat (2) @(negedge clk);
    chk(32'(unlocked), 32'h0);
    $display("test lock done");
  endtask

  // two memory partitions launched in consecutive cycles, both failing with different severities
  task automatic test_mem_online;
    unlock;
    cfg(SEL_MEM_CTRL, 7'h00, 32'h81);
    cfg(SEL_MEM_CTRL, 7'h01, 32'h7f);
    cfg(SEL_FAULT_MAP, 7'h00, 32'h2);
    cfg(SEL_FIRST_PTR, 7'h00, 32'h0);
    clear_counts;
    cfg(SEL_RUN, 7'h00, 32'hf);
    wait_starts(2);
    chk(32'(parts[0]), 32'h0);
    chk(32'(parts[1]), 32'h1);
    chk(32'(start_cyc[1] - start_cyc[0]), 32'h1);
    mem_done(7'h00, 1'b1);
    mem_done(7'h01, 1'b1);
    wait_idle;
    chk(32'(n_start), 32'h2);
    chk(32'(n_rec), 32'h1);
    chk(32'(n_unrec), 32'h1);
    chk(32'(n_irq), 32'h1);
    chk(32'({mpll, lpll}), 32'h3);
    chk(32'(n_fr), 32'h0);
    chk(st_low, 32'h0);
    $display("test mem online done");
  endtask

  task automatic test_mem_offline;
    unlock;
    // one partition in each result word, launched as a concurrent chain
    cfg(SEL_MEM_CTRL, 7'h00, 32'ha0);
    cfg(SEL_MEM_CTRL, 7'h20, 32'hc0);
    cfg(SEL_MEM_CTRL, 7'h40, 32'h7f);
    clear_counts;
    off_start = 1'b1;
    @(negedge clk);
    off_start = 1'b0;
    wait_starts(3);
    mem_done(7'h00, 1'b1);
    mem_done(7'h20, 1'b0);
    mem_done(7'h40, 1'b1);
    wait_idle;
    chk(st_low, 32'h1);
    chk(er_low, 32'h1);
    chk(st_mid, 32'h1);
    chk(er_mid, 32'h0);
    chk(st_high, 32'h1);
    chk(er_high, 32'h1);
    $display("test mem offline done");
  endtask

  task automatic test_logic;
    unlock;
    // partition 0 chains to partition 1, whose zero pattern count skips it
    cfg(SEL_LOGIC_CTRL, 7'h00, {LOGIC_CTRL_RESET[31:7], 7'h61});
    cfg(SEL_PATTERN_COUNT, 7'h00, 32'h2);
    cfg(SEL_FIRST_PTR, 7'h00, 32'h60);
    clear_counts;
    cfg(SEL_RUN, 7'h00, 32'h1);
    wait_idle;
    chk(32'(n_cap), 32'h2);
    chk(32'(flush_first > 0), 32'h1);
    chk(32'(cws_seen), 32'h7);
    chk(32'(n_fr), 32'h1);
    chk(ol_status, 32'h3);
    chk(ol_error, 32'h0);
    chk(32'(n_shift), 32'(FLUSH_LEN) + 32'(SHIFT_LEN) * 2);
    chk(32'(n_se_cap), 32'h0);
    chk(32'(lpart_seen), 32'h0);
    $display("test logic done");
  endtask

  task automatic test_logic_fail;
    unlock;
    cfg(SEL_FIRST_PTR, 7'h00, 32'h61);
    clear_counts;
    lfail = 1'b1;
    cfg(SEL_RUN, 7'h00, 32'h1);
    wait_idle;
    lfail = 1'b0;
    chk(ol_status, 32'h2);
    chk(ol_error, 32'h2);
    chk(32'(n_cap), 32'h0);
    chk(32'(n_fr), 32'h1);
    $display("test logic fail done");
  endtask

  // memory partition never reports back, so only the watchdog ends the run
  task automatic test_watchdog;
    unlock;
    cfg(SEL_WATCHDOG, 7'h00, 32'h40);
    cfg(SEL_MEM_CTRL, 7'h00, 32'h7f);
    cfg(SEL_FIRST_PTR, 7'h00, 32'h0);
    clear_counts;
    cfg(SEL_RUN, 7'h00, 32'h1);
    wait_idle;
    chk(32'(n_start), 32'h1);
    chk(32'(n_wdg), 32'h1);
    chk(32'(n_irq), 32'h0);
    $display("test watchdog done");
  endtask

  initial begin
    rst = 1'b1; wr = 1'b0; sel = SEL_KEY; idx = 7'h00; data = 32'h0;
    off_start = 1'b0; done = 1'b0; done_part = 7'h00; fail = 1'b0;
    lfail = 1'b0;
    failures = 0; checked = 0; cyc = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(32'(mem_part), 32'h7f);
    test_lock;
    test_mem_online;
    test_mem_offline;
    test_logic;
    test_logic_fail;
    test_watchdog;
    end_of_test;
  end
endmodule
